/* File: logic/psc_state_ctrl.sv */
// Power-state controller with I2C slave register port and password write gate
`timescale 1ns/1ps
module psc_state_ctrl
    import psc_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT,
    parameter int         WAKE_CYC   = WAKE_WAIT_CYC,
    parameter int         SLEEP_CYC  = SLEEP_DELAY_CYC,
    parameter int         RESET_CYC  = RESET_MIN_CYC,
    parameter int         PB_CYC     = PB_HOLD_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Pins from outside the clock domain
    input  wire psc_pins_t  pinsIn,
    // I2C data, open drain
    output logic            sdaOut,
    output logic            sdaOe,
    // Wake request to host, open drain
    output logic            wakeRequestOut,
    output logic            wakeRequestOe,
    // Rail and sequencer control
    output logic            nonSeqRailsOn,
    output logic            chargeEnable,
    output logic            seqUpStart,
    output logic            seqDownStart,
    output psc_state_t      powerState,
    output logic [7:0]      enableOut
);
    ////////////////////////////////////////////////////////////////////////////////
    psc_pins_t  syncA, syncB, pinPrev;
    psc_state_t stateReg, stateNext;
    psc_i2c_t   phase, nextPh;
    logic [31:0] timerReg, pbCnt;
    logic [7:0]  regs [REG_COUNT];
    logic [7:0]  shift, ptr, pw, pendAddr, pendData;
    logic [3:0]  bitCnt;
    logic [1:0]  pendStage;
    logic        nack, txnPw, txnOther;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            syncA   <= psc_pins_t'(PINS_IDLE);
            syncB   <= psc_pins_t'(PINS_IDLE);
            pinPrev <= psc_pins_t'(PINS_IDLE);
        end else begin
            syncA   <= pinsIn;
            syncB   <= syncA;
            pinPrev <= syncB;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    wire faultS  = syncB.fault;
    wire peS     = syncB.powerEnable;
    wire hardS   = syncB.hardResetN;
    wire peFall  = pinPrev.powerEnable & ~peS;
    wire wakeEvt = (pinPrev.pushButton & ~syncB.pushButton)
                 | (syncB.usb & ~pinPrev.usb) | (syncB.ac & ~pinPrev.ac);
    wire pbHit   = ~syncB.pushButton && pbCnt == 32'(PB_CYC - 1);
    wire offBit  = regs[ADDR_STATUS[4:0]][STATUS_OFF_BIT];
    wire stateChg = stateNext != stateReg;
    wire downGo  = stateChg && (stateNext == S_OFF || stateNext == S_SLEEPDN
                 || stateNext == S_RESET);
    // Registers are held at defaults through OFF and RESET, cleared on any drop
    wire regClear = stateReg == S_OFF || stateReg == S_RESET || downGo;

    always_comb begin
        stateNext = stateReg;
        unique case (stateReg)
            S_OFF:     if (wakeEvt && !faultS) stateNext = S_WAKE;
            S_WAKE:    if (peS) stateNext = S_ACTIVE;
                       else if (timerReg == 32'(WAKE_CYC - 1)) stateNext = S_OFF;
            S_ACTIVE:  if (peFall) stateNext = offBit ? S_OFF : S_SLEEPDN;
            S_SLEEPDN: if (timerReg == 32'(SLEEP_CYC - 1)) stateNext = S_SLEEP;
            S_SLEEP:   if (peS) stateNext = S_ACTIVE;
                       else if (wakeEvt) stateNext = S_WAKE;
            S_RESET:   if (hardS && timerReg >= 32'(RESET_CYC)) stateNext = S_WAKE;
        endcase
        if (stateReg != S_OFF && stateReg != S_RESET && (!hardS || pbHit))
            stateNext = S_RESET;
        if (faultS && stateReg != S_OFF)
            stateNext = S_OFF;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stateReg <= S_OFF;
            timerReg <= 32'h0;
            pbCnt    <= 32'h0;
        end else begin
            stateReg <= stateNext;
            timerReg <= stateChg ? 32'h0 : timerReg + ((&timerReg) ? 32'h0 : 32'h1);
            pbCnt    <= (syncB.pushButton || pbHit) ? 32'h0 : pbCnt + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Rails outside the sequencer, standby regulator one among them, stay on in SLEEP
    wire railsOffRst = stateReg == S_RESET && timerReg == 32'(SLEEP_CYC - 1);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nonSeqRailsOn  <= 1'b0;
            wakeRequestOe  <= 1'b0;
            wakeRequestOut <= 1'b0;
            seqUpStart     <= 1'b0;
            seqDownStart   <= 1'b0;
            chargeEnable   <= 1'b0;
            powerState     <= S_OFF;
            enableOut      <= 8'h00;
        end else begin
            if (stateChg && stateNext == S_WAKE)
                nonSeqRailsOn <= 1'b1;
            else if (stateNext == S_OFF || railsOffRst)
                nonSeqRailsOn <= 1'b0;
            wakeRequestOe  <= stateNext == S_WAKE && !peS;
            seqUpStart     <= stateChg && stateNext == S_ACTIVE;
            seqDownStart   <= downGo && stateReg != S_OFF;
            chargeEnable   <= stateNext != S_OFF && (syncB.usb || syncB.ac);
            powerState     <= stateNext;
            enableOut      <= regs[ADDR_ENABLE[4:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // SCL is sampled here; 25 clocks per bit at 400 kbit/s leaves ample margin
    wire sclRise = syncB.scl & ~pinPrev.scl;
    wire sclFall = ~syncB.scl & pinPrev.scl;
    wire startC  = syncB.scl & pinPrev.scl & pinPrev.sda & ~syncB.sda;
    wire stopC   = syncB.scl & pinPrev.scl & ~pinPrev.sda & syncB.sda;
    wire byteDone = bitCnt == 4'h8;
    wire inReg   = ptr < 8'(REG_COUNT);
    wire isPwReg = ptr == ADDR_PASSWORD;
    wire isProt  = ptr >= ADDR_PROT_LO && ptr <= ADDR_PROT_HI && !isPwReg;
    wire isL2    = ptr >= ADDR_L2_LO && ptr <= ADDR_L2_HI;
    wire pwOk    = (pw ^ ptr) == PW_KEY;
    wire pendMatch = pendStage == 2'h3 && pendAddr == ptr && pendData == shift;
    wire wrByte  = phase == I_WR && sclFall && byteDone;
    wire commit  = wrByte && inReg && !isPwReg && ptr != ADDR_CHIP
                 && (!isProt || (pwOk && (!isL2 || pendMatch)));
    wire store2  = wrByte && isProt && isL2 && pwOk && !pendMatch;
    wire rdLoad  = sclFall && ((phase == I_ACK && nextPh == I_RD)
                 || (phase == I_RACK && !nack));
    wire [7:0] rdByte = isPwReg ? pw : (inReg ? regs[ptr[4:0]] : 8'h00);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase  <= I_IDLE;
            nextPh <= I_IDLE;
            shift  <= 8'h00;
            bitCnt <= 4'h0;
            ptr    <= 8'h00;
            nack   <= 1'b0;
            sdaOe  <= 1'b0;
            sdaOut <= 1'b0;
        end else if (stateReg == S_OFF || stopC) begin
            phase <= I_IDLE;
            sdaOe <= 1'b0;
        end else if (startC) begin
            phase  <= I_ADDR;
            bitCnt <= 4'h0;
            sdaOe  <= 1'b0;
        end else if (sclRise) begin
            if (phase == I_ADDR || phase == I_SUB || phase == I_WR) begin
                shift  <= {shift[6:0], syncB.sda};
                bitCnt <= bitCnt + 4'h1;
            end
            if (phase == I_RACK)
                nack <= syncB.sda;
        end else if (rdLoad) begin
            shift  <= rdByte;
            sdaOe  <= ~rdByte[7];
            ptr    <= ptr + 8'h1;
            bitCnt <= 4'h1;
            phase  <= I_RD;
        end else if (sclFall) begin
            unique case (phase)
                I_ADDR: if (byteDone) begin
                    phase  <= shift[7:1] == SLAVE_ADDR ? I_ACK : I_IDLE;
                    sdaOe  <= shift[7:1] == SLAVE_ADDR;
                    nextPh <= shift[0] ? I_RD : I_SUB;
                end
                I_SUB, I_WR: if (byteDone) begin
                    ptr    <= phase == I_SUB ? shift : ptr + 8'h1;
                    phase  <= I_ACK;
                    sdaOe  <= 1'b1;
                    nextPh <= I_WR;
                end
                I_ACK: begin
                    phase  <= nextPh;
                    bitCnt <= 4'h0;
                    sdaOe  <= 1'b0;
                end
                I_RD: begin
                    phase  <= byteDone ? I_RACK : I_RD;
                    sdaOe  <= byteDone ? 1'b0 : ~shift[6];
                    shift  <= {shift[6:0], 1'b0};
                    bitCnt <= bitCnt + 4'h1;
                end
                I_RACK: phase <= I_IDLE;
                I_IDLE: phase <= I_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stage 1 stored, 2 after storing transfer, 3 after a lone password transfer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pw        <= 8'h00;
            txnPw     <= 1'b0;
            txnOther  <= 1'b0;
            pendStage <= 2'h0;
            pendAddr  <= 8'h00;
            pendData  <= 8'h00;
        end else if (regClear) begin
            pw        <= 8'h00;
            txnPw     <= 1'b0;
            txnOther  <= 1'b0;
            pendStage <= 2'h0;
        end else if (stopC) begin
            if (!txnPw)
                pw <= 8'h00;
            txnPw    <= 1'b0;
            txnOther <= 1'b0;
            unique case (pendStage)
                2'h1: pendStage <= 2'h2;
                2'h2: pendStage <= (txnPw && !txnOther) ? 2'h3 : 2'h0;
                default: pendStage <= 2'h0;
            endcase
        end else begin
            if (wrByte && isPwReg) begin
                pw    <= shift;
                txnPw <= 1'b1;
            end else if (wrByte || rdLoad)
                txnOther <= 1'b1;
            if (store2) begin
                pendStage <= 2'h1;
                pendAddr  <= ptr;
                pendData  <= shift;
            end else if (commit && pendMatch)
                pendStage <= 2'h0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < REG_COUNT; i++)
                regs[i] <= REG_DEFAULTS[8*i +: 8];
        end else if (regClear) begin
            for (int i = 0; i < REG_COUNT; i++)
                regs[i] <= REG_DEFAULTS[8*i +: 8];
        end else if (commit)
            regs[ptr[4:0]] <= shift;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pointer one cycle back: the write guard looks at the byte just taken, not the next
    logic [4:0] lastPtr;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            lastPtr <= 5'h00;
        else
            lastPtr <= ptr[4:0];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_off_needs_wake: assert property (stateReg == S_OFF && !wakeEvt |=> stateReg == S_OFF)
        else $error("OFF left without wake event");
    a_off_all_quiet: assert property (stateReg == S_OFF |-> !nonSeqRailsOn ##1 phase == I_IDLE)
        else $error("OFF with rail on or I2C active");
    a_off_via_bit: assert property (stateReg == S_ACTIVE && peFall && offBit
        && !faultS && hardS && !pbHit |=> stateReg == S_OFF)
        else $error("Off bit did not lead to OFF");
    a_fault_to_off: assert property (faultS && stateReg != S_OFF |=>
        stateReg == S_OFF ##1 !nonSeqRailsOn)
        else $error("Fault did not shut down");
    a_wake_signal: assert property (stateReg == S_OFF && stateNext == S_WAKE && !peS |=>
        wakeRequestOe && nonSeqRailsOn)
        else $error("Wake request not driven");
    a_enable_timeout: assert property (stateReg == S_WAKE && !peS && !faultS && hardS
        && !pbHit && timerReg == 32'(WAKE_CYC - 1) |=> stateReg == S_OFF)
        else $error("Power enable timeout missed");
    a_active_seq_up: assert property ($rose(stateReg == S_ACTIVE) |-> seqUpStart
        ##1 !seqUpStart && !wakeRequestOe)
        else $error("Sequencer not started on ACTIVE");
    a_sleep_resume: assert property (stateReg == S_SLEEP && peS && !faultS && hardS
        && !pbHit |=> stateReg == S_ACTIVE)
        else $error("SLEEP did not resume");
    a_sleep_delay: assert property (stateReg == S_SLEEPDN
        && timerReg == 32'(SLEEP_CYC - 1) && !faultS && hardS && !pbHit |=> stateReg == S_SLEEP)
        else $error("SLEEP not reached after delay");
    a_reset_hold: assert property (stateReg == S_RESET && !faultS && (!hardS
        || timerReg < 32'(RESET_CYC)) |=> stateReg == S_RESET)
        else $error("RESET left too early");
    a_password_clear: assert property (stopC && !txnPw && !regClear |=> pw == 8'h00)
        else $error("Password not cleared");
    a_guarded_write: assert property (wrByte && isProt && !pwOk && !regClear |=>
        regs[lastPtr] == $past(regs[ptr[4:0]]))
        else $error("Protected register written without password");

    c_wake_active: cover property (stateReg == S_WAKE ##1 stateReg == S_ACTIVE);
    c_sleep_entry: cover property (stateReg == S_SLEEPDN ##1 stateReg == S_SLEEP);
    c_reset_entry: cover property (stateReg == S_ACTIVE ##1 stateReg == S_RESET);
    c_level2_commit: cover property (commit && isL2);
endmodule : psc_state_ctrl

/* File: logic/psc_pkg.sv */
// Constants and types of the power-state controller and its I2C register port
package psc_pkg;
    localparam int CLK_HZ        = 10_000_000;
    // Times in seconds and their cycle counts
    localparam int WAKE_WAIT_S   = 5;
    localparam int SLEEP_DELAY_S = 1;
    localparam int RESET_MIN_S   = 1;
    localparam int PB_HOLD_S     = 8;
    localparam int WAKE_WAIT_CYC   = WAKE_WAIT_S * CLK_HZ;
    localparam int SLEEP_DELAY_CYC = SLEEP_DELAY_S * CLK_HZ;
    localparam int RESET_MIN_CYC   = RESET_MIN_S * CLK_HZ;
    localparam int PB_HOLD_CYC     = PB_HOLD_S * CLK_HZ;
    // Slave address value is arbitrary
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2A;
    localparam logic [7:0] PW_KEY         = 8'h7D;
    localparam logic [7:0] ADDR_STATUS    = 8'h0A;
    localparam logic [7:0] ADDR_PASSWORD  = 8'h0B;
    localparam logic [7:0] ADDR_PROT_LO   = 8'h0B;
    localparam logic [7:0] ADDR_PROT_HI   = 8'h1F;
    localparam logic [7:0] ADDR_L2_LO     = 8'h0E;
    localparam logic [7:0] ADDR_L2_HI     = 8'h15;
    localparam logic [7:0] ADDR_ENABLE    = 8'h16;
    localparam logic [7:0] ADDR_CHIP      = 8'h00;
    localparam int         STATUS_OFF_BIT = 7;
    localparam int         REG_COUNT      = 32;
    // Defaults, byte n at [8n+:8], 0x1F down to 0x00; chip code 8'h5A is arbitrary
    localparam logic [255:0] REG_DEFAULTS = {
        64'h0000_4000_0000_0003,
        64'h0000_0000_3809_0608,
        64'h0000_0C00_0000_0000,
        64'hB1B2_80B1_0080_3D5A};
    // Pins idle: button high, hard reset high, SCL and SDA high
    localparam logic [7:0] PINS_IDLE = 8'h8B;

    typedef enum {S_OFF, S_WAKE, S_ACTIVE, S_SLEEPDN, S_SLEEP, S_RESET} psc_state_t;
    typedef enum {I_IDLE, I_ADDR, I_SUB, I_WR, I_RD, I_ACK, I_RACK} psc_i2c_t;

    typedef struct packed {
        logic pushButton;
        logic usb;
        logic ac;
        logic powerEnable;
        logic hardResetN;
        logic fault;
        logic scl;
        logic sda;
    } psc_pins_t;
endpackage : psc_pkg

/* File: tb/psc_host_model.sv */
// Host model: I2C controller and power-enable handshake of the processor side
`timescale 1ns/1ps
module psc_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h31
) (
    // Open-drain data pulled by the slave
    input  wire logic       sdaOe,
    // Bus wires and power enable
    output logic            scl,
    output logic            sda,
    output logic            powerEnable,
    // Read results for the bench
    output logic            rdStrobe,
    output logic [7:0]      rdByte
);
    logic       sdaR = 1'b1;
    logic [6:0] dev  = DEV_ADDR;
    logic       ackOk;

    // Pull-up: the wire is low while either side pulls it
    assign sda = sdaR & ~sdaOe;

    initial begin
        scl = 1'b1;
        powerEnable = 1'b0;
        rdStrobe = 1'b0;
        rdByte = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // SCL stands high outside frames; each bit is 800 ns with 400 ns high
    task automatic bit_x(input logic b, output logic s);
        #200 sdaR = b;
        #200 scl = 1'b1;
        #200 s = sda;
        #200 scl = 1'b0;
    endtask : bit_x

    task automatic byte_x(input logic [7:0] tx, input logic mAck, output logic [7:0] rx,
                          output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], rx[i]);
        end
        bit_x(mAck, a);
    endtask : byte_x

    task automatic send(input logic [7:0] b);
        logic [7:0] r;
        logic       a;
        byte_x(b, 1'b1, r, a);
        ackOk &= ~a;
    endtask : send

    // One transaction: pointer, nW written bytes, then nR read bytes after a repeated start
    task automatic xact(input logic [7:0] sub, input logic [15:0] d, input int nW, input int nR);
        logic [7:0] r;
        logic       a;
        ackOk = 1'b1;
        #37;
        #200 sdaR = 1'b1;
        #200 scl = 1'b1;
        #400 sdaR = 1'b0;
        #400 scl = 1'b0;
        send({dev, 1'b0});
        send(sub);
        for (int i = nW - 1; i >= 0; i--) begin
            send(d[8*i+:8]);
        end
        if (nR > 0) begin
            #200 sdaR = 1'b1;
            #200 scl = 1'b1;
            #400 sdaR = 1'b0;
            #400 scl = 1'b0;
            send({dev, 1'b1});
            for (int i = nR - 1; i >= 0; i--) begin
                byte_x(8'hFF, i == 0, r, a);
                rdByte = r;
                rdStrobe = 1'b1;
                #1 rdStrobe = 1'b0;
            end
        end
        #200 sdaR = 1'b0;
        #200 scl = 1'b1;
        #400 sdaR = 1'b1;
        #400;
    endtask : xact

    // Level change only; the bench orders it after the off bit write
    task automatic set_en(input logic v);
        powerEnable = v;
    endtask : set_en
endmodule : psc_host_model

/* File: tb/tb_psc_state_ctrl.sv */
// Self-checking bench of the power-state controller and its I2C port
`timescale 1ns/1ps
module tb_psc_state_ctrl
    import psc_pkg::*;
;
    localparam int         SC  = 50;
    localparam int         RC  = 60;
    localparam int         PC  = 100;
    localparam int         WC  = 200;
    localparam logic [6:0] DEV = 7'h31;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       pb = 1'b1;
    logic       usb = 1'b0;
    logic       ac = 1'b0;
    logic       hrn = 1'b1;
    logic       flt = 1'b0;
    logic       scl, sda, pwrEn, rdStrobe, sdaOut, sdaOe, wakeRequestOut, wakeRequestOe;
    logic       nonSeqRailsOn, chargeEnable, seqUpStart, seqDownStart;
    logic [7:0] rdByte, enableOut, d;
    psc_state_t powerState;
    psc_state_t lastState = S_OFF;
    psc_pins_t  pinsIn;
    psc_state_t stateQ[$];
    logic [7:0] dataQ[$];
    int         err_total = 0;
    int         compares = 0;
    int         cyc = 0;
    int         upSeen = 0;
    int         downSeen = 0;
    int         seed = 32'h8589;

    assign pinsIn = '{pushButton: pb, usb: usb, ac: ac, powerEnable: pwrEn,
                      hardResetN: hrn, fault: flt, scl: scl, sda: sda};

    psc_state_ctrl #(.SLAVE_ADDR(DEV), .WAKE_CYC(WC), .SLEEP_CYC(SC), .RESET_CYC(RC),
                     .PB_CYC(PC)) dut (
        .clk(clk), .reset_n(reset_n), .pinsIn(pinsIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .wakeRequestOut(wakeRequestOut), .wakeRequestOe(wakeRequestOe),
        .nonSeqRailsOn(nonSeqRailsOn), .chargeEnable(chargeEnable), .seqUpStart(seqUpStart),
        .seqDownStart(seqDownStart), .powerState(powerState), .enableOut(enableOut));

    psc_host_model #(.DEV_ADDR(DEV)) host (
        .sdaOe(sdaOe), .scl(scl), .sda(sda), .powerEnable(pwrEn), .rdStrobe(rdStrobe),
        .rdByte(rdByte));

    initial forever #50 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // Outputs are registers, so the falling edge sees them settled
    always @(negedge clk) begin
        cyc <= cyc + 1;
        if (seqUpStart === 1'b1) upSeen <= upSeen + 1;
        if (seqDownStart === 1'b1) downSeen <= downSeen + 1;
        if (reset_n && powerState !== lastState) begin
            lastState <= powerState;
            check("powerState", powerState, stateQ.size() > 0 ? stateQ.pop_front() : 32'hFF);
        end
        if (cyc == 30000) begin
            err_total++;
            print_verdict();
        end
    end

    always @(posedge rdStrobe) begin
        check("readByte", rdByte, dataQ.size() > 0 ? dataQ.pop_front() : 32'h100);
    end

    task automatic go(input psc_state_t s, input int lim);
        stateQ.push_back(s);
        for (int i = 0; i < lim && powerState !== s; i++) @(negedge clk);
        check("stateReached", powerState, s);
    endtask : go

    task automatic rdchk(input logic [7:0] a, input logic [7:0] v);
        dataQ.push_back(v);
        host.xact(a, 16'h0000, 0, 1);
    endtask : rdchk

    // Password then data; a level-two register needs this pair twice
    task automatic pwr(input logic [7:0] a, input logic [7:0] v);
        host.xact(ADDR_PASSWORD, {8'h00, a ^ PW_KEY}, 1, 0);
        host.xact(a, {8'h00, v}, 1, 0);
        repeat (8) @(negedge clk);
    endtask : pwr

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        rdchk(ADDR_CHIP, 8'hFF);
        check("offNoAck", host.ackOk, 1'b0);
        @(negedge clk) pb = 1'b0;
        go(S_WAKE, 20);
        check("wakeLow", wakeRequestOe, 1'b1);
        check("railsOn", nonSeqRailsOn, 1'b1);
        @(negedge clk) pb = 1'b1;
        @(negedge clk) host.set_en(1'b1);
        go(S_ACTIVE, 20);
        repeat (3) @(negedge clk);
        check("upPulse", upSeen, 1);
        check("wakeFree", wakeRequestOe, 1'b0);
        for (int a = 0; a < 4; a++) dataQ.push_back(REG_DEFAULTS[8*a+:8]);
        host.xact(ADDR_CHIP, 16'h0000, 0, 4);
        check("ack", host.ackOk, 1'b1);
        host.dev = 7'h2A;
        host.xact(ADDR_STATUS, 16'h0080, 1, 0);
        check("otherAddr", host.ackOk, 1'b0);
        host.dev = DEV;
        d = 8'($random(seed));
        pwr(ADDR_ENABLE, d);
        check("level1", enableOut, d);
        host.xact(ADDR_ENABLE, {8'h00, ~d}, 1, 0);
        pwr(ADDR_ENABLE ^ 8'h01, ~d);
        pwr(ADDR_ENABLE ^ 8'h01, ~d);
        check("noPassword", enableOut, d);
        host.xact(ADDR_PASSWORD, {8'h00, ADDR_ENABLE ^ PW_KEY}, 1, 0);
        rdchk(ADDR_PASSWORD, ADDR_ENABLE ^ PW_KEY);
        rdchk(ADDR_PASSWORD, 8'h00);
        host.xact(ADDR_ENABLE, {8'h00, ~d}, 1, 0);
        check("pwCleared", enableOut, d);
        pwr(8'h12, d);
        rdchk(8'h12, REG_DEFAULTS[8*18+:8]);
        pwr(8'h12, d);
        pwr(8'h12, d);
        rdchk(8'h12, d);
        pwr(8'h12, ~d);
        rdchk(8'h12, d);
        pwr(8'h12, ~d);
        rdchk(8'h12, d);
        @(negedge clk) host.set_en(1'b0);
        go(S_SLEEPDN, 20);
        repeat (SC - 5) @(negedge clk);
        check("sleepDelay", powerState, S_SLEEPDN);
        check("downPulse", downSeen, 1);
        go(S_SLEEP, 10);
        check("regsDefault", enableOut, REG_DEFAULTS[8*22+:8]);
        check("standbyOn", nonSeqRailsOn, 1'b1);
        @(negedge clk) host.set_en(1'b1);
        go(S_ACTIVE, 20);
        rdchk(8'h12, REG_DEFAULTS[8*18+:8]);
        host.xact(ADDR_STATUS, 16'h0080, 1, 0);
        @(negedge clk) host.set_en(1'b0);
        go(S_OFF, 20);
        check("railsOff", nonSeqRailsOn, 1'b0);
        @(negedge clk) usb = 1'b1;
        go(S_WAKE, 20);
        check("charging", chargeEnable, 1'b1);
        repeat (WC - 10) @(negedge clk);
        check("wakeWait", powerState, S_WAKE);
        go(S_OFF, 30);
        repeat (20) @(negedge clk);
        check("usbLevel", powerState, S_OFF);
        @(negedge clk) ac = 1'b1;
        go(S_WAKE, 20);
        @(negedge clk) host.set_en(1'b1);
        go(S_ACTIVE, 20);
        @(negedge clk) flt = 1'b1;
        go(S_OFF, 20);
        @(negedge clk) pb = 1'b0;
        repeat (20) @(negedge clk);
        check("faultHolds", powerState, S_OFF);
        @(negedge clk) pb = 1'b1;
        @(negedge clk) flt = 1'b0;
        @(negedge clk) pb = 1'b0;
        stateQ.push_back(S_WAKE);
        @(negedge clk) pb = 1'b1;
        go(S_ACTIVE, 30);
        @(negedge clk) hrn = 1'b0;
        go(S_RESET, 20);
        @(negedge clk) hrn = 1'b1;
        repeat (RC - 15) @(negedge clk);
        check("resetMin", powerState, S_RESET);
        stateQ.push_back(S_WAKE);
        go(S_ACTIVE, 40);
        @(negedge clk) pb = 1'b0;
        go(S_RESET, PC + 20);
        stateQ.push_back(S_WAKE);
        go(S_ACTIVE, RC + 40);
        go(S_RESET, PC + 30);
        @(negedge clk) pb = 1'b1;
        stateQ.push_back(S_WAKE);
        go(S_ACTIVE, RC + 40);
        repeat (10) @(negedge clk);
        check("openDrainLow", {sdaOut, wakeRequestOut}, 2'b00);
        print_verdict();
    end
endmodule : tb_psc_state_ctrl
